// [logic/hsc_pkg.sv]
// Purpose: Shared constants for the halt standby controller.
// Assumes: APB with 32-bit data, pclk at 200 MHz.
// Notes:   Offsets are byte addresses of aligned words.
package hsc_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] HSC_OFF_CTRL   = 8'h00;
	localparam logic [7:0] HSC_OFF_OPTION = 8'h04;
	localparam logic [7:0] HSC_OFF_MASK   = 8'h08;
	localparam logic [7:0] HSC_OFF_STATUS = 8'h0c;

	// Control fields
	localparam int HSC_CTRL_CPU_SRC   = 0; // 1: high-speed clock, 0: low-speed
	localparam int HSC_CTRL_T51_DIV   = 1; // Timer 51 counts on low-speed / 2^7
	localparam int HSC_CTRL_SER_TB0   = 2; // Serial clock permit from timer_b0_running
	localparam int HSC_CTRL_LS_STOP   = 3; // Software stop of low-speed oscillator
	localparam logic [3:0] HSC_CTRL_RST = 4'h1;

	// Option fields, writable once
	localparam int HSC_OPT_STOPPABLE = 0;
	localparam int HSC_OPT_LOCKED    = 1;
	localparam logic [1:0] HSC_OPT_RST = 2'h0;

	localparam int          HSC_IRQ_N    = 8;
	localparam logic [7:0]  HSC_MASK_RST = 8'hff;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int PCLK_MHZ       = 200;
	localparam int LS_FREQ_KHZ    = 240;
	localparam int LS_DIV         = (PCLK_MHZ * 1000) / LS_FREQ_KHZ;
	localparam int LS_PRESCALE    = 128; // 2^7
	localparam logic [3:0] WAIT_VECTOR = 4'h8;
	localparam logic [3:0] WAIT_NEXT   = 4'h2;

	typedef enum logic [1:0] {
		HSC_RUN  = 2'b00,
		HSC_HALT = 2'b01,
		HSC_WAIT = 2'b11
	} hsc_state_t;

endpackage

// [logic/hsc_wait_cnt.sv]
// Purpose: Down counter timing the wait before the CPU clock restarts.
// Assumes: start is a one-cycle pulse with len at least 1.
// Notes:   expired is high in the last cycle of the wait.
`timescale 1ns/100ps
module hsc_wait_cnt (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       start,
	input  wire logic [3:0] len,
	output logic            expired
);
	import hsc_pkg::*;

	logic [3:0] cnt_q;
	logic       busy_q;

	// Final wait cycle
	assign expired = busy_q && (cnt_q == 4'h0);

	// Load and count down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q  <= 4'h0;
			busy_q <= 1'b0;
		end else if (start) begin
			cnt_q  <= len - 4'h1;
			busy_q <= 1'b1;
		end else if (expired) begin
			busy_q <= 1'b0;
		end else if (busy_q) begin
			cnt_q  <= cnt_q - 4'h1;
		end
	end
endmodule

// [logic/hsc_top.sv]
// Purpose: Halt standby control with APB registers.
// Assumes: CPU signals share pclk; interrupt requests are asynchronous pins.
// Notes:   presetn is the reset input; its release starts the reset branch.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/100ps
module hsc_top (
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [7:0]                      paddr,
	input  wire logic [31:0]                     pwdata,
	output logic [31:0]                          prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	input  wire logic                            halt_exec,
	input  wire logic                            cpu_int_enable,
	input  wire logic [hsc_pkg::HSC_IRQ_N-1:0]   irq_req,
	input  wire logic                            timer_b0_running,
	output logic                                 cpu_clk_en,
	output logic                                 port_latch_hold,
	output logic                                 vector_start,
	output logic                                 next_instr_start,
	output logic                                 reset_vector_start,
	output logic                                 timer_b1_count_en,
	output logic                                 async_serial_clk_ok,
	output logic                                 wdt_run,
	output logic                                 low_speed_osc_run
);
	import hsc_pkg::*;

	// ----------------------------------------
	// Registers and wires
	// ----------------------------------------
	hsc_state_t             state_q, state_d;
	logic [3:0]             ctrl_q;
	logic [1:0]             opt_q;
	logic [HSC_IRQ_N-1:0]   mask_q, irq_s1_q, irq_s2_q;
	logic [31:0]            prdata_q;
	logic                   pready_q, pslverr_q;
	logic                   clk_en_q, hold_q, vec_q, next_q, rstv_q, started_q;
	logic                   vec_pend_q, halt_hs_q, last_vec_q;
	logic                   t51_q, uart_q, wdt_q, lsrun_q;
	logic [9:0]             ls_div_q;
	logic [6:0]             ls_pre_q;
	logic                   wait_expired;

	wire setup   = psel && !penable;
	wire wr_acc  = psel && penable && pwrite;
	wire hit_ctl = paddr == HSC_OFF_CTRL;
	wire hit_opt = paddr == HSC_OFF_OPTION;
	wire hit_msk = paddr == HSC_OFF_MASK;
	wire hit_sts = paddr == HSC_OFF_STATUS;
	wire mapped  = hit_ctl || hit_opt || hit_msk || hit_sts;
	wire halted  = state_q == HSC_HALT;
	wire release_req = halted && |(irq_s2_q & ~mask_q);
	wire vec_take    = cpu_int_enable;
	wire ls_stopped  = opt_q[HSC_OPT_STOPPABLE] && ctrl_q[HSC_CTRL_LS_STOP];
	wire ls_tick     = lsrun_q && (ls_div_q == 10'(LS_DIV - 1));
	wire ls_tick128  = ls_tick && (ls_pre_q == 7'(LS_PRESCALE - 1));
	wire idle_low    = state_q != HSC_RUN && !halt_hs_q;
	wire [31:0] status_w = {27'h0, last_vec_q, lsrun_q, halted, state_q};
	wire [31:0] rd_mux = hit_ctl ? {28'h0, ctrl_q} :
	                     hit_opt ? {30'h0, opt_q} :
	                     hit_msk ? {24'h0, mask_q} :
	                     hit_sts ? status_w : 32'h0;

	// ----------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= 1'b1;
			if (setup) begin
				prdata_q  <= pwrite ? 32'h0 : rd_mux;
				pslverr_q <= !mapped || (pwrite && hit_sts);
			end
		end
	end

	// Software registers; option locks after first write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= HSC_CTRL_RST;
			opt_q  <= HSC_OPT_RST;
			mask_q <= HSC_MASK_RST;
		end else if (wr_acc) begin
			if (hit_ctl)
				ctrl_q <= pwdata[3:0];
			if (hit_opt && !opt_q[HSC_OPT_LOCKED])
				opt_q <= {1'b1, pwdata[HSC_OPT_STOPPABLE]};
			if (hit_msk)
				mask_q <= pwdata[HSC_IRQ_N-1:0];
		end
	end

	// Interrupt pin synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_s1_q <= '0;
			irq_s2_q <= '0;
		end else begin
			irq_s1_q <= irq_req;
			irq_s2_q <= irq_s1_q;
		end
	end

	// ----------------------------------------
	// Standby state machine
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			HSC_RUN:  if (halt_exec) state_d = HSC_HALT;
			HSC_HALT: if (release_req) state_d = HSC_WAIT;
			HSC_WAIT: if (wait_expired) state_d = HSC_RUN;
		endcase
	end

	hsc_wait_cnt u_wait (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (release_req),
		.len     (vec_take ? WAIT_VECTOR : WAIT_NEXT),
		.expired (wait_expired)
	);

	// Clock gate, latch hold and restart pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= HSC_RUN;
			clk_en_q   <= 1'b1;
			hold_q     <= 1'b0;
			vec_q      <= 1'b0;
			next_q     <= 1'b0;
			vec_pend_q <= 1'b0;
			halt_hs_q  <= 1'b1;
			last_vec_q <= 1'b0;
		end else begin
			state_q <= state_d;
			vec_q   <= 1'b0;
			next_q  <= 1'b0;
			if (state_q == HSC_RUN && halt_exec) begin
				clk_en_q  <= 1'b0;
				hold_q    <= 1'b1;
				halt_hs_q <= ctrl_q[HSC_CTRL_CPU_SRC];
			end
			if (release_req) begin
				vec_pend_q <= vec_take;
				last_vec_q <= vec_take;
			end
			if (state_q == HSC_WAIT && wait_expired) begin
				clk_en_q <= 1'b1;
				hold_q   <= 1'b0;
				vec_q    <= vec_pend_q;
				next_q   <= !vec_pend_q;
			end
		end
	end

	// Reset vector branch after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			started_q <= 1'b0;
			rstv_q    <= 1'b0;
		end else begin
			started_q <= 1'b1;
			rstv_q    <= !started_q;
		end
	end

	// ----------------------------------------
	// Low-speed clock enables
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ls_div_q <= 10'h0;
			ls_pre_q <= 7'h0;
			lsrun_q  <= 1'b1;
		end else begin
			lsrun_q <= !ls_stopped;
			if (lsrun_q)
				ls_div_q <= ls_tick ? 10'h0 : ls_div_q + 10'h1;
			if (ls_tick)
				ls_pre_q <= ls_pre_q + 7'h1;
		end
	end

	// Peripheral permits in halt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t51_q  <= 1'b0;
			uart_q <= 1'b1;
			wdt_q  <= 1'b1;
		end else begin
			if (ctrl_q[HSC_CTRL_T51_DIV])
				t51_q <= ls_tick128;
			else
				t51_q <= !idle_low;
			uart_q <= !idle_low || (ctrl_q[HSC_CTRL_SER_TB0] && timer_b0_running);
			wdt_q  <= !(halted && opt_q[HSC_OPT_STOPPABLE]);
		end
	end

	assign prdata              = prdata_q;
	assign pready              = pready_q;
	assign pslverr             = pslverr_q;
	assign cpu_clk_en          = clk_en_q;
	assign port_latch_hold     = hold_q;
	assign vector_start        = vec_q;
	assign next_instr_start    = next_q;
	assign reset_vector_start  = rstv_q;
	assign timer_b1_count_en   = t51_q;
	assign async_serial_clk_ok = uart_q;
	assign wdt_run             = wdt_q;
	assign low_speed_osc_run   = lsrun_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_halt_gates_clock: assert property (
		state_q == HSC_RUN && halt_exec |=> !cpu_clk_en && port_latch_hold)
		else $error("halt did not gate the cpu clock");
	chk_release_to_wait: assert property (
		release_req |=> state_q == HSC_WAIT)
		else $error("unmasked request did not release halt");
	chk_masked_holds: assert property (
		halted && !(|(irq_s2_q & ~mask_q)) |=> halted)
		else $error("halt left without unmasked request");
	chk_vector_wait: assert property (
		release_req && cpu_int_enable |=> !cpu_clk_en [*8] ##1 (cpu_clk_en && vector_start))
		else $error("vectored wait not eight clocks");
	chk_next_wait: assert property (
		release_req && !cpu_int_enable |=> !cpu_clk_en [*2] ##1 (cpu_clk_en && next_instr_start))
		else $error("non-vectored wait not two clocks");
	chk_reset_branch: assert property (
		$rose(started_q) |-> reset_vector_start && cpu_clk_en)
		else $error("reset branch pulse missing");
	chk_t51_low_halt: assert property (
		$past(ctrl_q[HSC_CTRL_T51_DIV]) && !$past(ls_tick128) |-> !timer_b1_count_en)
		else $error("timer 51 counted off the divided clock");
	chk_uart_permit: assert property (
		idle_low && !timer_b0_running |=> !async_serial_clk_ok)
		else $error("serial port permitted without timer clock");
	chk_wdt_stop: assert property (
		halted && opt_q[HSC_OPT_STOPPABLE] |=> !wdt_run)
		else $error("watchdog ran in halt while stoppable");
	chk_clean_restart: assert property (
		$rose(cpu_clk_en) |-> vector_start || next_instr_start)
		else $error("cpu clock restarted outside wait end");

	cov_vector_release: cover property (release_req && cpu_int_enable ##9 vector_start);
	cov_next_release:   cover property (release_req && !cpu_int_enable ##3 next_instr_start);
	cov_low_speed_halt: cover property (halted && !halt_hs_q);
endmodule

// [test/hsc_cpu_model.sv]
// Purpose: CPU core and interrupt source model facing the halt controller.
// Assumes: Levels change just after a rising pclk edge.
// Notes:   The bench calls its tasks to issue halts and requests.
`timescale 1ns/100ps
module hsc_cpu_model #(
	parameter int NOP_WAIT = 85
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	output logic                               halt_exec,
	output logic                               cpu_int_enable,
	output logic [hsc_pkg::HSC_IRQ_N-1:0]      irq_req,
	output logic                               timer_b0_running
);
	import hsc_pkg::*;
	int nop_cnt;

	// ----------------------------------------
	// Start-up no-op wait after reset
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nop_cnt <= 0;
		end else if (nop_cnt < NOP_WAIT) begin
			nop_cnt <= nop_cnt + 1;
		end
	end

	// Quiet lines at time zero
	initial begin
		halt_exec = 1'b0;
		cpu_int_enable = 1'b0;
		irq_req = '0;
		timer_b0_running = 1'b0;
	end

	// Request levels and acknowledge enable
	task automatic set_lines(input logic ie, input logic [7:0] irq, input logic t0);
		@(posedge pclk);
		cpu_int_enable <= ie;
		irq_req <= irq;
		timer_b0_running <= t0;
	endtask

	// One-cycle halt instruction, only once start-up wait is over
	task automatic halt();
		while (nop_cnt < NOP_WAIT) @(posedge pclk);
		@(posedge pclk);
		halt_exec <= 1'b1;
		@(posedge pclk);
		halt_exec <= 1'b0;
	endtask
endmodule

// [test/halt_standby_control_tb.sv]
// Purpose: Self-checking bench for the halt standby controller.
// Assumes: Zero-wait APB slave; CPU model drives halt and requests.
// Notes:   Latencies compared as vectored minus plain release.
`timescale 1ns/100ps
module halt_standby_control_tb;
	import hsc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic        cpu_clk_en, port_latch_hold, vector_start, next_instr_start;
	logic        reset_vector_start, timer_b1_count_en, async_serial_clk_ok;
	logic        wdt_run, low_speed_osc_run;
	wire logic   halt_exec, cpu_int_enable, timer_b0_running;
	wire logic [HSC_IRQ_N-1:0] irq_req;
	int          fails, samples_checked, lv, ln;

	hsc_top i_hsc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .halt_exec(halt_exec), .cpu_int_enable(cpu_int_enable),
		.irq_req(irq_req), .timer_b0_running(timer_b0_running), .cpu_clk_en(cpu_clk_en),
		.port_latch_hold(port_latch_hold), .vector_start(vector_start),
		.next_instr_start(next_instr_start), .reset_vector_start(reset_vector_start),
		.timer_b1_count_en(timer_b1_count_en), .async_serial_clk_ok(async_serial_clk_ok),
		.wdt_run(wdt_run), .low_speed_osc_run(low_speed_osc_run));
	hsc_cpu_model i_hsc_cpu_model (.pclk(pclk), .presetn(presetn), .halt_exec(halt_exec),
		.cpu_int_enable(cpu_int_enable), .irq_req(irq_req),
		.timer_b0_running(timer_b0_running));

	// ----------------------------------------
	// Clock, verdict and compare
	// ----------------------------------------
	always #2.5 pclk = ~pclk;

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			fails++;
			$display("BAD t=%0t apb transfer got no ready", $time);
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Reset held 17 cycles, then the reset branch pulse
	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		@(negedge pclk);
		chk({31'h0, cpu_clk_en}, 32'h1, "clock en in reset");
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		@(negedge pclk);
		chk({31'h0, reset_vector_start}, 32'h1, "reset branch");
		@(negedge pclk);
		chk({31'h0, reset_vector_start}, 32'h0, "reset branch width");
	endtask

	// Halt with a masked request, check peripherals, unmask, time release
	task automatic halt_cycle(input logic vec, input logic t0, input logic [2:0] per,
		output int lat);
		i_hsc_cpu_model.set_lines(vec, 8'h01, t0);
		i_hsc_cpu_model.halt();
		repeat (4) @(negedge pclk);
		chk({30'h0, cpu_clk_en, port_latch_hold}, 32'h1, "halted");
		chk({29'h0, timer_b1_count_en, async_serial_clk_ok, wdt_run}, {29'h0, per},
			"peripherals");
		apb(1'b0, HSC_OFF_STATUS, 32'h0);
		chk(rdata & 32'h7, 32'h5, "status halted");
		apb(1'b1, HSC_OFF_MASK, 32'hfe);
		lat = 0;
		while (vector_start !== 1'b1 && next_instr_start !== 1'b1 && lat < 40) begin
			@(negedge pclk);
			lat++;
		end
		chk({28'h0, vector_start, next_instr_start, cpu_clk_en, port_latch_hold},
			{28'h0, vec, ~vec, 2'b10}, "release");
		apb(1'b1, HSC_OFF_MASK, 32'hff);
	endtask

	// ----------------------------------------
	// Watchdog and main sequence
	// ----------------------------------------
	initial begin
		#100000;
		fails++;
		print_verdict();
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		do_reset();
		apb(1'b0, HSC_OFF_CTRL, 32'h0);
		chk(rdata, 32'h1, "ctrl reset");
		apb(1'b0, HSC_OFF_MASK, 32'h0);
		chk(rdata, 32'hff, "mask reset");
		apb(1'b0, HSC_OFF_STATUS, 32'h0);
		chk(rdata, 32'h8, "status reset");
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, rerr}, 32'h1, "unmapped");
		apb(1'b1, HSC_OFF_STATUS, 32'h1f);
		chk({31'h0, rerr}, 32'h1, "status write");
		halt_cycle(1'b1, 1'b1, 3'b111, lv);
		halt_cycle(1'b0, 1'b1, 3'b111, ln);
		chk(32'(lv - ln), 32'h6, "wait difference");
		apb(1'b1, HSC_OFF_CTRL, 32'h4);
		halt_cycle(1'b0, 1'b1, 3'b011, ln);
		apb(1'b1, HSC_OFF_CTRL, 32'h0);
		halt_cycle(1'b1, 1'b1, 3'b001, lv);
		apb(1'b1, HSC_OFF_CTRL, 32'h6);
		halt_cycle(1'b0, 1'b0, 3'b001, ln);
		apb(1'b1, HSC_OFF_OPTION, 32'h1);
		apb(1'b1, HSC_OFF_OPTION, 32'h0);
		apb(1'b0, HSC_OFF_OPTION, 32'h0);
		chk(rdata, 32'h3, "option once");
		apb(1'b1, HSC_OFF_CTRL, 32'h9);
		halt_cycle(1'b1, 1'b1, 3'b110, lv);
		chk({31'h0, low_speed_osc_run}, 32'h0, "osc stopped");
		i_hsc_cpu_model.halt();
		repeat (3) @(negedge pclk);
		chk({31'h0, cpu_clk_en}, 32'h0, "halt before reset");
		do_reset();
		chk({30'h0, cpu_clk_en, port_latch_hold}, 32'h2, "reset ends halt");
		print_verdict();
	end
endmodule
